// file: thermclip_pkg.sv
// Package of offsets, fields, reset values and decode constants for the gain-protection registers.
package thermclip_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_RIGHT_LIMIT_THRESHOLD_SLOPE = 8'h12;
	localparam logic [7:0] OFS_RIGHT_BATTERY_KNEE          = 8'h13;
	localparam logic [7:0] OFS_LEFT_CLIP_LEVEL             = 8'h14;
	localparam logic [7:0] OFS_RIGHT_CLIP_LEVEL            = 8'h15;
	localparam logic [7:0] OFS_THERMAL_WARNING_ATTENUATION = 8'h16;

	// ****************************************
	// Reset values and writable-bit masks
	// ****************************************
	localparam logic [7:0] RST_RIGHT_LIMIT_THRESHOLD_SLOPE = 8'h51;
	localparam logic [7:0] RST_RIGHT_BATTERY_KNEE          = 8'h22;
	localparam logic [7:0] RST_LEFT_CLIP_LEVEL             = 8'hFF;
	localparam logic [7:0] RST_RIGHT_CLIP_LEVEL            = 8'hFF;
	localparam logic [7:0] RST_THERMAL_WARNING_ATTENUATION = 8'h00;
	localparam logic [7:0] MASK_RIGHT_LIMIT_THRESHOLD_SLOPE = 8'hFB;
	localparam logic [7:0] MASK_THERMAL_WARNING_ATTENUATION = 8'h33;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int THR_MSB       = 7;
	localparam int THR_LSB       = 3;
	localparam int SLOPE_MSB     = 1;
	localparam int SLOPE_LSB     = 0;
	localparam int ATTEN_R_MSB   = 5;
	localparam int ATTEN_R_LSB   = 4;
	localparam int ATTEN_L_MSB   = 1;
	localparam int ATTEN_L_LSB   = 0;

	// ****************************************
	// Threshold decode, in millivolts
	// ****************************************
	localparam logic [13:0] THR_TOP_MV      = 14'h3E80;
	localparam logic [13:0] THR_FINE_TOP_MV = 14'h251C;
	localparam logic [13:0] THR_LOW_TOP_MV  = 14'h1F40;
	localparam logic [13:0] THR_STEP_COARSE = 14'h01F4;
	localparam logic [13:0] THR_STEP_FINE   = 14'h00FA;
	localparam logic [4:0]  THR_FINE_START  = 5'h0D;
	localparam logic [4:0]  THR_FINE_END    = 5'h13;

	// ****************************************
	// Limiter modes and attenuation steps of 0.125 dB
	// ****************************************
	typedef enum logic [1:0] {
		LIM_OFF        = 2'b00,
		LIM_ON         = 2'b01,
		LIM_MUTE_LOW   = 2'b10,
		LIM_ON_IF_LOW  = 2'b11
	} limiter_mode_e;

	localparam logic [7:0] ATTEN_L_TABLE [4] = '{8'h00, 8'h0C, 8'h18, 8'h2D};
	localparam logic [7:0] ATTEN_R_TABLE [4] = '{8'h00, 8'h0C, 8'h18, 8'hC8};

endpackage : thermclip_pkg

// file: limit_threshold_track.sv
// Limiter threshold decoder with battery-tracking ramp-down.
`timescale 1ns/100ps
module limit_threshold_track #(
	parameter int BAT_LSB_MV = 100
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [4:0]  thr_code,
	input  wire logic [1:0]  slope,
	input  wire logic [7:0]  knee,
	input  wire logic [7:0]  vbat,
	input  wire logic        track_en,
	output      logic [13:0] threshold_mv,
	output      logic        below_knee
);

	function automatic logic [13:0] decode_mv(input logic [4:0] c);
		logic [13:0] cw;
		cw = {9'h000, c};
		if (c <= thermclip_pkg::THR_FINE_START)
			decode_mv = 14'(thermclip_pkg::THR_TOP_MV - cw * thermclip_pkg::THR_STEP_COARSE);
		else if (c <= thermclip_pkg::THR_FINE_END)
			decode_mv = 14'(thermclip_pkg::THR_FINE_TOP_MV
				- (cw - 14'(thermclip_pkg::THR_FINE_START)) * thermclip_pkg::THR_STEP_FINE);
		else
			decode_mv = 14'(thermclip_pkg::THR_LOW_TOP_MV
				- (cw - 14'(thermclip_pkg::THR_FINE_END)) * thermclip_pkg::THR_STEP_COARSE);
	endfunction : decode_mv

	logic [13:0] base_mv;
	logic [23:0] drop_mv;
	logic        below_now;
	logic [13:0] threshold_nxt;

	// The drop is recomputed every cycle, so the threshold follows the battery as it sags.
	always_comb begin
		base_mv   = decode_mv(thr_code);
		below_now = vbat < knee;
		drop_mv   = 24'h000000;
		if (track_en && below_now)
			drop_mv = 24'({16'h0000, 8'(knee - vbat)} * ({22'h000000, slope} + 24'h000001)
				* 24'(BAT_LSB_MV));
		if (drop_mv >= {10'h000, base_mv})
			threshold_nxt = 14'h0000;
		else
			threshold_nxt = base_mv - drop_mv[13:0];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			threshold_mv <= 14'h0000;
			below_knee   <= 1'b0;
		end else begin
			threshold_mv <= threshold_nxt;
			below_knee   <= below_now;
		end
	end

	property p_fixed_threshold;
		@(posedge clk) disable iff (srst)
		!track_en |=> threshold_mv == decode_mv($past(thr_code));
	endproperty
	a_fixed_threshold: assert property (p_fixed_threshold)
		else $error("Threshold moved while tracking was off.");

	property p_lowest_code;
		@(posedge clk) disable iff (srst)
		(thr_code == 5'h1F && !track_en) |=> threshold_mv == 14'h07D0;
	endproperty
	a_lowest_code: assert property (p_lowest_code)
		else $error("Code 31 did not decode to 2 V.");

endmodule : limit_threshold_track

// file: thermclip_regs.sv
// Gain-protection register bank: limiter threshold, knee, clip levels and thermal attenuation.
// ****************************************
// Operation
// ****************************************
`timescale 1ns/100ps
module thermclip_regs #(
	parameter int BAT_LSB_MV = 100
) (
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic        REG_WR_EN,
	input  wire logic [7:0]  REG_WR_DATA,
	input  wire logic        REG_RD_EN,
	output      logic [7:0]  REG_RD_DATA,
	input  wire logic [7:0]  BATTERY_VOLTAGE,
	input  wire logic        THERMAL_EARLY_WARNING,
	input  wire logic        CHANNEL_LIMITER_JOIN,
	input  wire logic        RIGHT_TRACK_EN,
	input  wire logic [1:0]  RIGHT_LIMITER_MODE,
	input  wire logic        LEFT_TRACK_EN,
	input  wire logic [1:0]  LEFT_LIMITER_MODE,
	input  wire logic [4:0]  LEFT_THRESHOLD_CODE,
	input  wire logic [1:0]  LEFT_SLOPE,
	input  wire logic [7:0]  LEFT_BATTERY_KNEE,
	output      logic [13:0] RIGHT_LIMIT_THRESHOLD_MV,
	output      logic        RIGHT_LIMITER_ACTIVE,
	output      logic        RIGHT_MUTE,
	output      logic [8:0]  LEFT_CLIP_LIMIT,
	output      logic [8:0]  RIGHT_CLIP_LIMIT,
	output      logic [7:0]  LEFT_HEAT_ATTEN,
	output      logic [7:0]  RIGHT_HEAT_ATTEN
);

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] thr_slope_r;
	logic [7:0] knee_r;
	logic [7:0] left_clip_r;
	logic [7:0] right_clip_r;
	logic [7:0] atten_r;
	logic [7:0] rd_data_nxt;

	// Reserved bits are masked on the way in, so they are never stored and always read zero.
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			thr_slope_r  <= thermclip_pkg::RST_RIGHT_LIMIT_THRESHOLD_SLOPE;
			knee_r       <= thermclip_pkg::RST_RIGHT_BATTERY_KNEE;
			left_clip_r  <= thermclip_pkg::RST_LEFT_CLIP_LEVEL;
			right_clip_r <= thermclip_pkg::RST_RIGHT_CLIP_LEVEL;
			atten_r      <= thermclip_pkg::RST_THERMAL_WARNING_ATTENUATION;
		end else if (REG_WR_EN) begin
			unique case (REG_ADDR)
				thermclip_pkg::OFS_RIGHT_LIMIT_THRESHOLD_SLOPE: begin
					thr_slope_r <= REG_WR_DATA & thermclip_pkg::MASK_RIGHT_LIMIT_THRESHOLD_SLOPE;
				end
				thermclip_pkg::OFS_RIGHT_BATTERY_KNEE: begin
					knee_r <= REG_WR_DATA;
				end
				thermclip_pkg::OFS_LEFT_CLIP_LEVEL: begin
					left_clip_r <= REG_WR_DATA;
				end
				thermclip_pkg::OFS_RIGHT_CLIP_LEVEL: begin
					right_clip_r <= REG_WR_DATA;
				end
				thermclip_pkg::OFS_THERMAL_WARNING_ATTENUATION: begin
					atten_r <= REG_WR_DATA & thermclip_pkg::MASK_THERMAL_WARNING_ATTENUATION;
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_comb begin
		unique case (REG_ADDR)
			thermclip_pkg::OFS_RIGHT_LIMIT_THRESHOLD_SLOPE: rd_data_nxt = thr_slope_r;
			thermclip_pkg::OFS_RIGHT_BATTERY_KNEE:          rd_data_nxt = knee_r;
			thermclip_pkg::OFS_LEFT_CLIP_LEVEL:             rd_data_nxt = left_clip_r;
			thermclip_pkg::OFS_RIGHT_CLIP_LEVEL:            rd_data_nxt = right_clip_r;
			thermclip_pkg::OFS_THERMAL_WARNING_ATTENUATION: rd_data_nxt = atten_r;
			default:                                        rd_data_nxt = 8'h00;
		endcase
	end

	// Read data holds until the next read, so a slow controller may sample it late.
	always_ff @(posedge REF_CLK) begin
		if (SRST)
			REG_RD_DATA <= 8'h00;
		else if (REG_RD_EN)
			REG_RD_DATA <= rd_data_nxt;
	end

	// ****************************************
	// Right limiter threshold and mode
	// ****************************************
	logic [4:0]  sel_thr_code;
	logic [1:0]  sel_slope;
	logic [7:0]  sel_knee;
	logic        sel_track;
	logic [1:0]  sel_mode;
	logic        below_knee;
	logic [13:0] threshold_mv;

	always_comb begin
		if (CHANNEL_LIMITER_JOIN) begin
			sel_thr_code = LEFT_THRESHOLD_CODE;
			sel_slope    = LEFT_SLOPE;
			sel_knee     = LEFT_BATTERY_KNEE;
			sel_track    = LEFT_TRACK_EN;
			sel_mode     = LEFT_LIMITER_MODE;
		end else begin
			sel_thr_code = thr_slope_r[thermclip_pkg::THR_MSB:thermclip_pkg::THR_LSB];
			sel_slope    = thr_slope_r[thermclip_pkg::SLOPE_MSB:thermclip_pkg::SLOPE_LSB];
			sel_knee     = knee_r;
			sel_track    = RIGHT_TRACK_EN;
			sel_mode     = RIGHT_LIMITER_MODE;
		end
	end

	limit_threshold_track #(
		.BAT_LSB_MV (BAT_LSB_MV)
	) u_limit_threshold_track (
		.clk          (REF_CLK),
		.srst         (SRST),
		.thr_code     (sel_thr_code),
		.slope        (sel_slope),
		.knee         (sel_knee),
		.vbat         (BATTERY_VOLTAGE),
		.track_en     (sel_track),
		.threshold_mv (threshold_mv),
		.below_knee   (below_knee)
	);

	assign RIGHT_LIMIT_THRESHOLD_MV = threshold_mv;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			RIGHT_LIMITER_ACTIVE <= 1'b0;
			RIGHT_MUTE           <= 1'b0;
		end else begin
			unique case (thermclip_pkg::limiter_mode_e'(sel_mode))
				thermclip_pkg::LIM_OFF: begin
					RIGHT_LIMITER_ACTIVE <= 1'b0;
					RIGHT_MUTE           <= 1'b0;
				end
				thermclip_pkg::LIM_ON: begin
					RIGHT_LIMITER_ACTIVE <= 1'b1;
					RIGHT_MUTE           <= 1'b0;
				end
				thermclip_pkg::LIM_MUTE_LOW: begin
					RIGHT_LIMITER_ACTIVE <= 1'b0;
					RIGHT_MUTE           <= below_knee;
				end
				thermclip_pkg::LIM_ON_IF_LOW: begin
					RIGHT_LIMITER_ACTIVE <= below_knee;
					RIGHT_MUTE           <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Clip levels and thermal attenuation
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			LEFT_CLIP_LIMIT  <= 9'h100;
			RIGHT_CLIP_LIMIT <= 9'h100;
		end else begin
			LEFT_CLIP_LIMIT  <= {1'b0, left_clip_r} + 9'h001;
			RIGHT_CLIP_LIMIT <= {1'b0, right_clip_r} + 9'h001;
		end
	end

	// Attenuation only applies while the warning stands; it drops to zero as soon as it clears.
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			LEFT_HEAT_ATTEN  <= 8'h00;
			RIGHT_HEAT_ATTEN <= 8'h00;
		end else if (THERMAL_EARLY_WARNING) begin
			LEFT_HEAT_ATTEN  <= thermclip_pkg::ATTEN_L_TABLE[
				atten_r[thermclip_pkg::ATTEN_L_MSB:thermclip_pkg::ATTEN_L_LSB]];
			RIGHT_HEAT_ATTEN <= thermclip_pkg::ATTEN_R_TABLE[
				atten_r[thermclip_pkg::ATTEN_R_MSB:thermclip_pkg::ATTEN_R_LSB]];
		end else begin
			LEFT_HEAT_ATTEN  <= 8'h00;
			RIGHT_HEAT_ATTEN <= 8'h00;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence s_write_to(logic [7:0] ofs);
		REG_WR_EN && REG_ADDR == ofs;
	endsequence

	sequence s_read_from(logic [7:0] ofs);
		REG_RD_EN && REG_ADDR == ofs && !REG_WR_EN;
	endsequence

	property p_knee_roundtrip;
		@(posedge REF_CLK) disable iff (SRST)
		s_write_to(thermclip_pkg::OFS_RIGHT_BATTERY_KNEE) ##1 !REG_WR_EN ##1
			s_read_from(thermclip_pkg::OFS_RIGHT_BATTERY_KNEE)
		|=> REG_RD_DATA == $past(REG_WR_DATA, 3);
	endproperty
	a_knee_roundtrip: assert property (p_knee_roundtrip)
		else $error("Knee value did not read back as written.");

	property p_slope_write;
		@(posedge REF_CLK) disable iff (SRST)
		s_write_to(thermclip_pkg::OFS_RIGHT_LIMIT_THRESHOLD_SLOPE)
		|=> thr_slope_r[1:0] == $past(REG_WR_DATA[1:0]) && thr_slope_r[2] == 1'b0;
	endproperty
	a_slope_write: assert property (p_slope_write)
		else $error("Slope field not stored or reserved bit set.");

	property p_reserved_read;
		@(posedge REF_CLK) disable iff (SRST)
		s_read_from(thermclip_pkg::OFS_THERMAL_WARNING_ATTENUATION)
		|=> REG_RD_DATA[7:6] == 2'b00 && REG_RD_DATA[3:2] == 2'b00;
	endproperty
	a_reserved_read: assert property (p_reserved_read)
		else $error("Reserved attenuation bits read nonzero.");

	property p_left_clip;
		@(posedge REF_CLK) disable iff (SRST)
		s_write_to(thermclip_pkg::OFS_LEFT_CLIP_LEVEL) ##1 !REG_WR_EN
		|=> LEFT_CLIP_LIMIT == {1'b0, $past(REG_WR_DATA, 2)} + 9'h001;
	endproperty
	a_left_clip: assert property (p_left_clip)
		else $error("Left clip limit wrong after write.");

	property p_right_clip_full;
		@(posedge REF_CLK) disable iff (SRST)
		right_clip_r == 8'hFF |=> RIGHT_CLIP_LIMIT == 9'h100;
	endproperty
	a_right_clip_full: assert property (p_right_clip_full)
		else $error("Right clip code 0xFF is not full scale.");

	property p_right_atten;
		@(posedge REF_CLK) disable iff (SRST)
		THERMAL_EARLY_WARNING && atten_r[5:4] == 2'b11 |=> RIGHT_HEAT_ATTEN == 8'hC8;
	endproperty
	a_right_atten: assert property (p_right_atten)
		else $error("Right attenuation code 3 not 25 dB.");

	property p_left_atten;
		@(posedge REF_CLK) disable iff (SRST)
		THERMAL_EARLY_WARNING && atten_r[1:0] == 2'b11 |=> LEFT_HEAT_ATTEN == 8'h2D;
	endproperty
	a_left_atten: assert property (p_left_atten)
		else $error("Left attenuation code 3 not 5.625 dB.");

	property p_no_warn_no_atten;
		@(posedge REF_CLK) disable iff (SRST)
		!THERMAL_EARLY_WARNING |=> LEFT_HEAT_ATTEN == 8'h00 && RIGHT_HEAT_ATTEN == 8'h00;
	endproperty
	a_no_warn_no_atten: assert property (p_no_warn_no_atten)
		else $error("Attenuation applied without a warning.");

	property p_mute_mode;
		@(posedge REF_CLK) disable iff (SRST)
		sel_mode == 2'b10 |=> RIGHT_MUTE == $past(below_knee) && !RIGHT_LIMITER_ACTIVE;
	endproperty
	a_mute_mode: assert property (p_mute_mode)
		else $error("Mute mode did not follow the knee comparison.");

	property p_join_left_mode;
		@(posedge REF_CLK) disable iff (SRST)
		CHANNEL_LIMITER_JOIN && LEFT_LIMITER_MODE == 2'b01 |=> RIGHT_LIMITER_ACTIVE;
	endproperty
	a_join_left_mode: assert property (p_join_left_mode)
		else $error("Joined limiter ignored the left mode.");

endmodule : thermclip_regs

// file: thermclip_regs_tb.sv
// Self-checking testbench for the gain-protection register bank.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
	$display("Error at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module thermclip_regs_tb;
	localparam int BAT_MV = 100;
	logic        ref_clk;
	logic        srst;
	logic [7:0]  reg_addr;
	logic        reg_wr_en;
	logic [7:0]  reg_wr_data;
	logic        reg_rd_en;
	logic [7:0]  vbat;
	logic        warn;
	logic        join_en;
	logic        r_track;
	logic [1:0]  r_mode;
	logic        l_track;
	logic [1:0]  l_mode;
	logic [4:0]  l_code;
	logic [1:0]  l_slope;
	logic [7:0]  l_knee;
	logic [7:0]  rd_data;
	logic [13:0] thr_mv;
	logic        lim_act;
	logic        mute;
	logic [8:0]  clip_l;
	logic [8:0]  clip_r;
	logic [7:0]  heat_l;
	logic [7:0]  heat_r;
	logic [7:0]  shadow [5];
	logic [7:0]  rnd;
	logic [7:0]  kn;
	int          errors;
	int          n_tests;
	logic [7:0]  msk [5] = '{8'hFB, 8'hFF, 8'hFF, 8'hFF, 8'h33};

	thermclip_regs #(.BAT_LSB_MV(BAT_MV)) u_thermclip_regs (
		.REF_CLK(ref_clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WR_EN(reg_wr_en),
		.REG_WR_DATA(reg_wr_data), .REG_RD_EN(reg_rd_en), .REG_RD_DATA(rd_data),
		.BATTERY_VOLTAGE(vbat), .THERMAL_EARLY_WARNING(warn),
		.CHANNEL_LIMITER_JOIN(join_en), .RIGHT_TRACK_EN(r_track),
		.RIGHT_LIMITER_MODE(r_mode), .LEFT_TRACK_EN(l_track), .LEFT_LIMITER_MODE(l_mode),
		.LEFT_THRESHOLD_CODE(l_code), .LEFT_SLOPE(l_slope), .LEFT_BATTERY_KNEE(l_knee),
		.RIGHT_LIMIT_THRESHOLD_MV(thr_mv), .RIGHT_LIMITER_ACTIVE(lim_act),
		.RIGHT_MUTE(mute), .LEFT_CLIP_LIMIT(clip_l), .RIGHT_CLIP_LIMIT(clip_r),
		.LEFT_HEAT_ATTEN(heat_l), .RIGHT_HEAT_ATTEN(heat_r)
	);

	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;

	// ****************************************
	// Reference model
	// ****************************************
	function automatic int base_mv(input int c);
		if (c <= 13) return 16000 - 500 * c;
		if (c <= 19) return 9500 - 250 * (c - 13);
		return 8000 - 500 * (c - 19);
	endfunction : base_mv

	// Attenuation in eighths of a decibel; only the top right code differs from the left.
	function automatic int heat(input int code, input int right);
		case (code)
			1: return 12;
			2: return 24;
			3: return right ? 200 : 45;
			default: return 0;
		endcase
	endfunction : heat

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next

	task automatic step_rnd();
		rnd = lfsr_next(rnd);
	endtask : step_rnd

	task automatic report_and_stop();
		$display("Summary: %0d comparisons, %0d mismatches", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic do_reset();
		srst = 1'b1;
		repeat (10) @(negedge ref_clk);
		srst = 1'b0;
		shadow = '{8'h51, 8'h22, 8'hFF, 8'hFF, 8'h00};
	endtask : do_reset

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge ref_clk);
		reg_wr_en = 1'b0;
		if (a >= 8'h12 && a <= 8'h16) shadow[a - 8'h12] = d & msk[a - 8'h12];
	endtask : wr

	task automatic rd_chk(input logic [7:0] a);
		logic [7:0] e;
		e = (a >= 8'h12 && a <= 8'h16) ? shadow[a - 8'h12] : 8'h00;
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge ref_clk);
		reg_rd_en = 1'b0;
		`CHK(rd_data, e)
	endtask : rd_chk

	task automatic check_dp();
		int code, slp, knee, trk, md, thr, below;
		repeat (3) @(negedge ref_clk);
		if (join_en) begin
			code = l_code; slp = l_slope; knee = l_knee; trk = l_track; md = l_mode;
		end else begin
			code = shadow[0][7:3]; slp = shadow[0][1:0]; knee = shadow[1];
			trk = r_track; md = r_mode;
		end
		thr = base_mv(code);
		below = (vbat < knee);
		if (trk && below) thr = thr - (knee - vbat) * (slp + 1) * BAT_MV;
		if (thr < 0) thr = 0;
		`CHK(thr_mv, thr[13:0])
		`CHK(lim_act, (md == 1) || (md == 3 && below))
		`CHK(mute, (md == 2) && below)
		`CHK(clip_l, {1'b0, shadow[2]} + 9'h001)
		`CHK(clip_r, {1'b0, shadow[3]} + 9'h001)
		`CHK(heat_l, warn ? heat(shadow[4][1:0], 0) : 0)
		`CHK(heat_r, warn ? heat(shadow[4][5:4], 1) : 0)
	endtask : check_dp

	task automatic reset_check(input string name);
		for (int a = 16; a < 24; a++) rd_chk(a[7:0]);
		check_dp();
		$display("Test done: %s", name);
	endtask : reset_check

	// The watchdog cuts a hang short; the longest sequence is far below this bound.
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		$display("Error at %0t ns: got %0h expected %0h", $time, 0, 1);
		report_and_stop();
	end

	initial begin
		errors = 0; n_tests = 0; rnd = 8'h59;
		srst = 1'b1; reg_addr = 8'h00; reg_wr_en = 1'b0; reg_wr_data = 8'h00;
		reg_rd_en = 1'b0; vbat = 8'h40; warn = 1'b0; join_en = 1'b0; r_track = 1'b0;
		r_mode = 2'h0; l_track = 1'b0; l_mode = 2'h0; l_code = 5'h00; l_slope = 2'h0;
		l_knee = 8'h22;
		do_reset();
		reset_check("reset values");
		// Reserved bits and unmapped offsets are written with random data too.
		for (int r = 0; r < 6; r++) begin
			for (int a = 17; a < 24; a++) begin
				step_rnd();
				wr(a[7:0], rnd);
			end
			for (int a = 17; a < 24; a++) rd_chk(a[7:0]);
			step_rnd();
			wr(8'h13, rnd);
			rd_chk(8'h13);
		end
		$display("Test done: register access");
		// Every threshold code, slope, mode and attenuation code, near the knee.
		for (int i = 0; i < 64; i++) begin
			step_rnd();
			kn = 8'h20 + {1'b0, rnd[6:0]};
			step_rnd();
			@(negedge ref_clk);
			vbat = kn + 8'h03 - {5'h00, rnd[2:0]};
			warn = rnd[3];
			join_en = (i >= 48);
			r_track = rnd[4] && (i != 31);
			l_track = rnd[5];
			r_mode = i[1:0];
			l_mode = i[3:2];
			l_code = 5'(31 - (i % 32));
			l_slope = rnd[7:6];
			l_knee = kn;
			step_rnd();
			wr(8'h12, {i[4:0], rnd[2], i[3:2]});
			wr(8'h13, kn);
			step_rnd();
			wr(8'h14, (i == 0) ? 8'h00 : rnd);
			step_rnd();
			wr(8'h15, (i == 1) ? 8'hFE : rnd);
			step_rnd();
			wr(8'h16, {rnd[7:6], i[1:0], rnd[3:2], i[3:2]});
			check_dp();
		end
		$display("Test done: datapath decode");
		do_reset();
		reset_check("reset in mid-run");
		report_and_stop();
	end
endmodule : thermclip_regs_tb
